// >>> pss_pkg.sv
package pss_pkg;

    // Command codes of the status bytes
    localparam logic [7:0] CMD_PORT1_STATUS = 8'h0c;
    localparam logic [7:0] CMD_PORT2_STATUS = 8'h0d;
    localparam logic [7:0] CMD_PORT3_STATUS = 8'h0e;
    localparam logic [7:0] CMD_PORT4_STATUS = 8'h0f;
    localparam logic [7:0] CMD_POWER_STATE = 8'h10;
    localparam logic [7:0] CMD_STRAP_STATE = 8'h11;

    // Geometry
    localparam int NUM_PORTS = 4;
    localparam int CLASS_LSB = 4;
    localparam int DETECT_LSB = 0;
    localparam int PG_LSB = 4;
    localparam int ON_LSB = 0;
    localparam int STRAP_LSB = 3;
    localparam int ADDR_LSB_POS = 2;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] POWER_RST = 8'h00;
    localparam logic [2:0] CLASS_RST = 3'h0;
    localparam logic [3:0] DETECT_RST = 4'h0;

    // Classification codes
    localparam logic [2:0] CLS_UNKNOWN = 3'h0;
    localparam logic [2:0] CLS_RESERVED = 3'h5;
    localparam logic [2:0] CLS_ZERO = 3'h6;
    localparam logic [2:0] CLS_OVERCURRENT = 3'h7;

    // Detection codes
    localparam logic [3:0] DET_UNKNOWN = 4'h0;
    localparam logic [3:0] DET_SHORT = 4'h1;
    localparam logic [3:0] DET_TOO_LOW = 4'h3;
    localparam logic [3:0] DET_VALID = 4'h4;
    localparam logic [3:0] DET_TOO_HIGH = 4'h5;
    localparam logic [3:0] DET_OPEN = 4'h6;
    localparam logic [3:0] DET_FET_FAULT = 4'he;

    // Low target address bit in the first configuration
    localparam logic ADDR_LSB_CFG_A = 1'b1;

    // One result report from the detection and classification engines
    typedef struct packed {
        logic cls_vld;
        logic [2:0] cls_code;
        logic det_vld;
        logic [3:0] det_code;
    } pss_result_s;

    // Held state of one port
    typedef struct packed {
        logic [2:0] port_class_result;
        logic [3:0] port_detect_result;
        logic power_good;
    } pss_port_state_s;

endpackage

// >>> pss_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin levels
module pss_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Async reset, high
    input wire logic [WIDTH-1:0] i_async, // Level from a pin
    output logic [WIDTH-1:0] o_sync // Level safe to use
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by the second

    // Both stages clear on reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule

// >>> pss_port_track.sv
`timescale 1ns/1ns
// Result and power-good tracking for one port
module pss_port_track (
    input wire logic i_clk, // Clock
    input wire logic i_rst, // Async reset, high
    input wire pss_pkg::pss_result_s i_result, // Engine result report
    input wire logic i_on, // Port on level
    input wire logic i_on_evt, // Port has just turned on
    input wire logic i_off_evt, // Port turn-off or undervoltage shutdown
    input wire logic i_ton_done, // Turn-on sequence finished
    input wire logic i_drain_low, // Drain sense below power-good threshold
    output pss_pkg::pss_port_state_s o_state // Held port state
);
    logic [2:0] cls_r; // Latest class code
    logic [3:0] det_r; // Latest detection code
    logic ton_r; // Turn-on in progress
    logic pg_r; // Power good

    // Reserved class code reads as class 0
    function automatic logic [2:0] map_class(input logic [2:0] code);
        return (code == pss_pkg::CLS_RESERVED) ? pss_pkg::CLS_ZERO : code;
    endfunction

    // Class field; a fresh result beats a same-cycle turn-off
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cls_r <= pss_pkg::CLASS_RST;
        end else if (i_result.cls_vld) begin
            cls_r <= map_class(i_result.cls_code); // RULE1 RULE3
        end else if (i_off_evt) begin
            cls_r <= pss_pkg::CLASS_RST; // RULE2 RULE13
        end
    end

    // Detection field; reserved codes are stored as reported
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            det_r <= pss_pkg::DETECT_RST;
        end else if (i_result.det_vld) begin
            det_r <= i_result.det_code; // RULE1 RULE4
        end else if (i_off_evt) begin
            det_r <= pss_pkg::DETECT_RST; // RULE2 RULE13
        end
    end

    // Window in which power good may be judged
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ton_r <= 1'b0;
        end else if (!i_on) begin
            ton_r <= 1'b0;
        end else if (i_on_evt) begin
            ton_r <= 1'b1;
        end else if (i_ton_done) begin
            ton_r <= 1'b0;
        end
    end

    // Power good latches high and only falls with the port
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pg_r <= 1'b0;
        end else if (!i_on) begin
            pg_r <= 1'b0; // RULE8 RULE10
        end else if (ton_r && i_drain_low) begin
            pg_r <= 1'b1; // RULE7
        end
    end

    assign o_state = '{port_class_result: cls_r, port_detect_result: det_r, power_good: pg_r};
endmodule

// >>> pss_status_regs.sv
`timescale 1ns/1ns
// Summary of operation
// RULE1: Status bytes hold latest class and detect results
// RULE2: Turning a port off zeroes its results
// RULE3: Class in bits 6-4, reserved reads class0
// RULE4: Detect code occupies bits 3 to 0
// RULE5: Port 4 status at command 0Fh, resets zero
// RULE6: Power byte 10h: good flags high, on low
// RULE7: Good set only when on, drain low, turning on
// RULE8: Good stays set until off or reset
// RULE9: On flag follows the port on state
// RULE10: Turn-off, even by fault, clears both flags
// RULE11: Pin byte 11h carries straps in bits 6-3
// RULE12: Low address bit zero in second configuration
// RULE13: Supply undervoltage shutdown also clears results
// RULE14: Low address bit is internally defined
// RULE15: Writes to these bytes are ignored
module pss_status_regs (
    input wire logic I_CLK, // 20 MHz clock
    input wire logic I_RST, // Async reset, high
    input wire pss_pkg::pss_result_s [3:0] I_RESULT, // Engine results, one per port
    input wire logic [3:0] I_PORT_ON, // Port on levels from the power stage
    input wire logic [3:0] I_TURN_ON_DONE, // Turn-on finished pulses
    input wire logic [3:0] I_UV_SHUTDOWN, // Supply undervoltage shutdown pulses
    input wire logic [3:0] I_DRAIN_LOW, // Drain sense comparators, async
    input wire logic [3:0] I_ADDR_STRAP, // Address strap pins 4..1, async
    input wire logic I_CONFIG_B, // Second configuration strap, async
    input wire logic [7:0] I_CMD, // Command code
    input wire logic I_RD_STB, // Read request pulse
    input wire logic I_WR_STB, // Write request pulse
    input wire logic [7:0] I_WR_DATA, // Write data, unused
    output logic [7:0] O_RD_DATA, // Read data
    output logic O_RD_VLD, // Read data valid pulse
    output logic O_RD_MISS, // Read of an unmapped code
    output logic O_WR_IGN // Write was ignored pulse
);
    logic [3:0] on_r; // Registered port on levels
    logic [3:0] on_evt; // Port turning on
    logic [3:0] off_evt; // Port turning off or shut down
    logic [3:0] drain_s; // Synchronised drain sense
    logic [3:0] strap_s; // Synchronised straps
    logic cfgb_s; // Synchronised configuration strap
    pss_pkg::pss_port_state_s [3:0] port_st; // Per-port held state
    logic [3:0] pg_vec; // Power good flags
    logic [27:0] cd_vec; // All class and detect fields
    logic addr_lsb; // Low target address bit
    logic [7:0] rd_nxt; // Read data next value
    logic miss_nxt; // Unmapped read next value

    // Status byte layout, bit 7 always zero
    function automatic logic [7:0] status_byte(input pss_pkg::pss_port_state_s st);
        return {1'b0, st.port_class_result, st.port_detect_result}; // RULE3 RULE4
    endfunction

    // Drain sense and straps are pins, so synchronise them
    pss_sync #(
        .WIDTH(9)
    ) u_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_async({I_CONFIG_B, I_ADDR_STRAP, I_DRAIN_LOW}),
        .o_sync({cfgb_s, strap_s, drain_s})
    );

    // Port on levels come from same-clock logic
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            on_r <= 4'h0;
        end else begin
            on_r <= I_PORT_ON; // RULE9
        end
    end

    // Edges of the on level; undervoltage counts as a turn-off
    assign on_evt = I_PORT_ON & ~on_r;
    assign off_evt = (on_r & ~I_PORT_ON) | I_UV_SHUTDOWN; // RULE2 RULE13

    // One tracker per port
    for (genvar p = 0; p < pss_pkg::NUM_PORTS; p++) begin : g_port
        pss_port_track u_track (
            .i_clk(I_CLK),
            .i_rst(I_RST),
            .i_result(I_RESULT[p]),
            .i_on(I_PORT_ON[p]),
            .i_on_evt(on_evt[p]),
            .i_off_evt(off_evt[p]),
            .i_ton_done(I_TURN_ON_DONE[p]),
            .i_drain_low(drain_s[p]),
            .o_state(port_st[p])
        );
    end

    // Gather flags and fields into vectors
    always_comb begin
        pg_vec = 4'h0;
        cd_vec = 28'h0;
        for (int p = 0; p < pss_pkg::NUM_PORTS; p++) begin
            pg_vec[p] = port_st[p].power_good;
            cd_vec[p*7 +: 7] = {port_st[p].port_class_result, port_st[p].port_detect_result};
        end
    end

    // Low address bit is fixed inside; forced to zero in configuration B
    assign addr_lsb = cfgb_s ? 1'b0 : pss_pkg::ADDR_LSB_CFG_A; // RULE12 RULE14

    // Command decode for reads
    always_comb begin
        rd_nxt = 8'h00;
        miss_nxt = 1'b0;
        if (I_CMD == pss_pkg::CMD_PORT1_STATUS) begin
            rd_nxt = status_byte(port_st[0]); // RULE1
        end else if (I_CMD == pss_pkg::CMD_PORT2_STATUS) begin
            rd_nxt = status_byte(port_st[1]);
        end else if (I_CMD == pss_pkg::CMD_PORT3_STATUS) begin
            rd_nxt = status_byte(port_st[2]);
        end else if (I_CMD == pss_pkg::CMD_PORT4_STATUS) begin
            rd_nxt = status_byte(port_st[3]); // RULE5
        end else if (I_CMD == pss_pkg::CMD_POWER_STATE) begin
            rd_nxt = {pg_vec, on_r}; // RULE6 RULE9
        end else if (I_CMD == pss_pkg::CMD_STRAP_STATE) begin
            rd_nxt = {1'b0, strap_s, addr_lsb, 2'b00}; // RULE11
        end else begin
            miss_nxt = 1'b1; // Unmapped code reads zero
        end
    end

    // Read answer registered one cycle after the strobe
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RD_DATA <= pss_pkg::STATUS_RST;
            O_RD_VLD <= 1'b0;
            O_RD_MISS <= 1'b0;
        end else begin
            O_RD_VLD <= I_RD_STB;
            O_RD_MISS <= I_RD_STB & miss_nxt;
            if (I_RD_STB) begin
                O_RD_DATA <= rd_nxt;
            end
        end
    end

    // Writes touch no state; only acknowledged as ignored
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_WR_IGN <= 1'b0;
        end else begin
            O_WR_IGN <= I_WR_STB; // RULE15
        end
    end

    // Checks per port
    for (genvar p = 0; p < pss_pkg::NUM_PORTS; p++) begin : g_chk
        result_upd_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE1
            I_RESULT[p].det_vld |=> port_st[p].port_detect_result == $past(I_RESULT[p].det_code))
            else $error("detect field did not take new result");
        off_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE2
            off_evt[p] && !I_RESULT[p].cls_vld && !I_RESULT[p].det_vld
            |=> port_st[p].port_class_result == 3'h0 && port_st[p].port_detect_result == 4'h0)
            else $error("results not cleared at turn-off");
        class_map_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE3
            I_RESULT[p].cls_vld |=> port_st[p].port_class_result ==
                (($past(I_RESULT[p].cls_code) == 3'h5) ? 3'h6 : $past(I_RESULT[p].cls_code)))
            else $error("class code stored wrongly");
        pg_cause_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE7
            $rose(port_st[p].power_good) |-> $past(I_PORT_ON[p]) && $past(drain_s[p]))
            else $error("power good set without cause");
        pg_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE8
            port_st[p].power_good && I_PORT_ON[p] |=> port_st[p].power_good)
            else $error("power good dropped while on");
        off_flags_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE10
            on_r[p] && !I_PORT_ON[p] |=> !port_st[p].power_good && !on_r[p])
            else $error("power flags not cleared at turn-off");
        pg_needs_on_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE9
            port_st[p].power_good |-> on_r[p])
            else $error("power good without port on");
    end

    // Register reads and writes, and undervoltage clearing
    port4_read_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE5
        I_RD_STB && I_CMD == 8'h0f |=> O_RD_VLD && O_RD_DATA == {1'b0, $past(cd_vec[27:21])})
        else $error("port 4 status read wrong");
    power_read_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE6
        I_RD_STB && I_CMD == 8'h10 |=> O_RD_DATA == {$past(pg_vec), $past(I_PORT_ON, 2)})
        else $error("power status read wrong");
    strap_read_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE11
        I_RD_STB && I_CMD == 8'h11 |=> O_RD_DATA[7] == 1'b0 && O_RD_DATA[1:0] == 2'h0
            && O_RD_DATA[6:3] == $past(strap_s))
        else $error("pin status read wrong");
    addr_lsb_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE12
        I_RD_STB && I_CMD == 8'h11 && cfgb_s |=> !O_RD_DATA[2])
        else $error("low address bit set in configuration B");
    write_ign_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE15
        I_WR_STB && I_RESULT == '0 && I_PORT_ON == on_r && I_UV_SHUTDOWN == 4'h0 |=> $stable(cd_vec) && O_WR_IGN)
        else $error("write changed status");
    uv_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST) // RULE13
        I_UV_SHUTDOWN[0] && !I_RESULT[0].cls_vld && !I_RESULT[0].det_vld |=> cd_vec[6:0] == 7'h00)
        else $error("undervoltage did not clear port 1 results");
    unmapped_a: assert property (@(posedge I_CLK) disable iff (I_RST) // Unmapped code reads zero and is flagged
        I_RD_STB && I_CMD == 8'h12 |=> O_RD_MISS && O_RD_DATA == 8'h00)
        else $error("unmapped read not flagged");
endmodule

// >>> pss_host_model.sv
`timescale 1ns/1ns
// Host controller side of the status register port
module pss_host_model (
    input wire logic i_clk, // Clock
    input wire logic [7:0] i_rd_data, // Read data from the block
    input wire logic i_rd_vld, // Read answer pulse
    input wire logic i_rd_miss, // Unmapped code flag
    input wire logic i_wr_ign, // Write refused pulse
    output logic [7:0] o_cmd, // Command code
    output logic o_rd_stb, // Read request
    output logic o_wr_stb, // Write request
    output logic [7:0] o_wr_data // Write data
);
    // Bus idle from time zero
    initial begin
        o_cmd = 8'h00;
        o_rd_stb = 1'b0;
        o_wr_stb = 1'b0;
        o_wr_data = 8'h00;
    end

    // Read: gap idle cycles first, so the host can be quick or slow
    task automatic rd(input logic [7:0] cmd, input int gap, output logic [7:0] data, output logic vld,
                      output logic miss);
        repeat (gap) @(posedge i_clk);
        o_cmd <= cmd;
        o_rd_stb <= 1'b1;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
        // Code scrambled after the taking edge so a late sample shows up
        o_cmd <= ~cmd;
        #1;
        data = i_rd_data;
        vld = i_rd_vld;
        miss = i_rd_miss;
        @(posedge i_clk);
    endtask

    // Write: no idle gap first, the refusal pulse is sampled after the taking edge
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data, output logic ign);
        o_cmd <= cmd;
        o_wr_data <= data;
        o_wr_stb <= 1'b1;
        @(posedge i_clk);
        o_wr_stb <= 1'b0;
        o_wr_data <= ~data;
        #1;
        ign = i_wr_ign;
        @(posedge i_clk);
    endtask
endmodule

// >>> pss_status_regs_tb.sv
`timescale 1ns/1ns
// Self-checking bench for the port status registers
module pss_status_regs_tb;
    logic clk; // 20 MHz clock
    logic rst; // Async reset
    pss_pkg::pss_result_s [3:0] result; // Engine reports
    logic [3:0] port_on, ton_done, uv, drain_low, strap; // Port side stimulus
    logic cfg_b; // Second configuration strap
    logic [7:0] cmd, wr_data, rd_data; // Register port
    logic rd_stb, wr_stb, rd_vld, rd_miss, wr_ign; // Strobes and answers
    int fail_count, checks, i, p; // Counters and loop indices
    logic [7:0] exp_stat [4]; // Expected port status bytes
    logic [3:0] det_tab [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'he}; // Detect codes
    logic ign; // Write refusal seen

    pss_status_regs dut (.I_CLK(clk), .I_RST(rst), .I_RESULT(result), .I_PORT_ON(port_on),
        .I_TURN_ON_DONE(ton_done), .I_UV_SHUTDOWN(uv), .I_DRAIN_LOW(drain_low), .I_ADDR_STRAP(strap),
        .I_CONFIG_B(cfg_b), .I_CMD(cmd), .I_RD_STB(rd_stb), .I_WR_STB(wr_stb), .I_WR_DATA(wr_data),
        .O_RD_DATA(rd_data), .O_RD_VLD(rd_vld), .O_RD_MISS(rd_miss), .O_WR_IGN(wr_ign));
    pss_host_model host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_vld(rd_vld), .i_rd_miss(rd_miss),
        .i_wr_ign(wr_ign), .o_cmd(cmd), .o_rd_stb(rd_stb), .o_wr_stb(wr_stb), .o_wr_data(wr_data));

    // Status byte as stored: reserved class reads as class 0
    function automatic logic [7:0] exp_byte(input logic [2:0] c, input logic [3:0] dt);
        return {1'b0, (c === pss_pkg::CLS_RESERVED) ? pss_pkg::CLS_ZERO : c, dt};
    endfunction

    // Single compare point
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Read through the host and compare data, valid and miss
    task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp, input logic miss_exp);
        logic [7:0] d;
        logic v;
        logic m;
        host.rd(c, $urandom_range(0, 2), d, v, m);
        chk("read data", d, exp);
        chk("read flags", {6'h00, v, m}, {6'h00, 1'b1, miss_exp});
    endtask

    // One result report, pulse taken at the second edge
    task automatic res(input int pn, input logic [2:0] c, input logic [3:0] dt);
        @(posedge clk);
        result[pn] <= {1'b1, c, 1'b1, dt};
        @(posedge clk);
        result[pn] <= '0;
        exp_stat[pn] = exp_byte(c, dt);
    endtask

    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        result = '0;
        {port_on, ton_done, uv, drain_low, strap, cfg_b} = '0;
        exp_stat = '{8'h00, 8'h00, 8'h00, 8'h00};
        void'($urandom(32'h8d52));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values of the four status bytes and the power byte
        for (i = 0; i < 5; i++) rd_chk(pss_pkg::CMD_PORT1_STATUS + 8'(i), 8'h00, 1'b0);
        // Pin byte after reset: straps low, low address bit is the fixed one
        rd_chk(pss_pkg::CMD_STRAP_STATE, {5'h00, pss_pkg::ADDR_LSB_CFG_A, 2'b00}, 1'b0);
        rd_chk(8'h12, 8'h00, 1'b1);
        // Straps in both configurations; synchroniser needs two edges
        for (i = 0; i < 2; i++) begin
            strap <= 4'($urandom);
            cfg_b <= i[0];
            repeat (4) @(posedge clk);
            rd_chk(pss_pkg::CMD_STRAP_STATE, {1'b0, strap, i ? 1'b0 : pss_pkg::ADDR_LSB_CFG_A, 2'b00}, 1'b0);
        end
        // Every class and detect code on random ports
        for (i = 0; i < 9; i++) begin
            p = $urandom_range(0, 3);
            res(p, i[2:0], det_tab[i]);
            rd_chk(pss_pkg::CMD_PORT1_STATUS + 8'(p), exp_stat[p], 1'b0);
        end
        // Writes are refused and leave the byte alone
        p = $urandom_range(0, 3);
        host.wr(pss_pkg::CMD_PORT1_STATUS + 8'(p), 8'($urandom), ign);
        chk("write ignored", {7'h00, ign}, 8'h01);
        rd_chk(pss_pkg::CMD_PORT1_STATUS + 8'(p), exp_stat[p], 1'b0);
        // Turn-on with drain low inside the window
        port_on[p] <= 1'b1;
        @(posedge clk);
        drain_low[p] <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(pss_pkg::CMD_POWER_STATE, 8'h11 << p, 1'b0);
        ton_done[p] <= 1'b1;
        @(posedge clk);
        ton_done[p] <= 1'b0;
        drain_low[p] <= 1'b0;
        repeat (4) @(posedge clk);
        rd_chk(pss_pkg::CMD_POWER_STATE, 8'h11 << p, 1'b0);
        res(p, 3'h1, pss_pkg::DET_VALID);
        port_on[p] <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(pss_pkg::CMD_POWER_STATE, 8'h00, 1'b0);
        rd_chk(pss_pkg::CMD_PORT1_STATUS + 8'(p), 8'h00, 1'b0);
        // Drain low only after the window closed: on without good
        port_on[p] <= 1'b1;
        @(posedge clk);
        ton_done[p] <= 1'b1;
        @(posedge clk);
        ton_done[p] <= 1'b0;
        drain_low[p] <= 1'b1;
        repeat (6) @(posedge clk);
        rd_chk(pss_pkg::CMD_POWER_STATE, 8'h01 << p, 1'b0);
        port_on[p] <= 1'b0;
        drain_low[p] <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk(pss_pkg::CMD_POWER_STATE, 8'h00, 1'b0);
        // Supply undervoltage shutdown clears the results
        res(p, 3'h4, pss_pkg::DET_OPEN);
        uv[p] <= 1'b1;
        @(posedge clk);
        uv[p] <= 1'b0;
        repeat (2) @(posedge clk);
        rd_chk(pss_pkg::CMD_PORT1_STATUS + 8'(p), 8'h00, 1'b0);
        report_and_stop();
    end
endmodule
